/* hw/cbr_avl.sv */
// avalon-mm slave holding the config word and reading back status
`timescale 1ns/100ps
`default_nettype none
module cbr_avl (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [31:0] status,
	output logic [31:0]      cfg
);
	logic [31:0] cfg_q;
	logic [31:0] rdata_q;
	logic        wait_q;
	logic        take;

	// one wait cycle, then the answer for one cycle
	assign take = (avs_read | avs_write) & wait_q;

	always_ff @(posedge mclk) begin
		if (rst) begin
			wait_q <= 1'b1;
		end else begin
			wait_q <= ~take;
		end
	end

	// ----------------------------------------------------------------
	// config write with byte lanes
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			cfg_q <= cbr_pkg::CFG_RST;
		end else if (take && avs_write && avs_address == cbr_pkg::OFS_CONFIG) begin
			for (int i = 0; i < 4; i++) begin
				if (avs_byteenable[i]) begin
					cfg_q[i*8 +: 8] <= avs_writedata[i*8 +: 8] & cbr_pkg::CFG_MASK[i*8 +: 8];
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_q <= 32'h0000_0000;
		end else if (take && avs_read) begin
			if (avs_address == cbr_pkg::OFS_CONFIG) begin
				rdata_q <= cfg_q;
			end else if (avs_address == cbr_pkg::OFS_STATUS) begin
				rdata_q <= status;
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	assign avs_readdata    = rdata_q;
	assign avs_waitrequest = wait_q;
	assign cfg             = cfg_q;

endmodule : cbr_avl
`default_nettype wire

/* hw/cbr_pkg.sv */
// constants, types and helpers shared by the configurable block ram
package cbr_pkg;

	// ----------------------------------------------------------------
	// array geometry
	// ----------------------------------------------------------------
	localparam int          ADDR_W      = 14;
	localparam int          MATCH_W     = 3;
	localparam int          WIDE_BITS   = 18432;
	localparam int          NARROW_BITS = 16384;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0]  OFS_CONFIG  = 4'h0;
	localparam logic [3:0]  OFS_STATUS  = 4'h4;

	// config field positions
	localparam int          CFG_POL_A   = 0;
	localparam int          CFG_POL_B   = 2;
	localparam int          CFG_PIPE    = 4;
	localparam int          CFG_ASYNC   = 5;
	localparam int          CFG_GSR     = 6;
	localparam int          CFG_PSEUDO  = 7;
	localparam int          CFG_MATCH_A = 8;
	localparam int          CFG_MATCH_B = 12;
	localparam logic [31:0] CFG_MASK    = 32'h0000_77FF;
	localparam logic [31:0] CFG_RST     = 32'h0000_0040;

	// status field positions
	localparam int          STS_BUSY    = 0;
	localparam int          STS_WIDTH   = 8;

	// ----------------------------------------------------------------
	// write output policy
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CBR_WR_NORMAL,
		CBR_WR_THROUGH,
		CBR_WR_OLD,
		CBR_WR_SPARE
	} cbr_policy_t;

	// words held for a given word width
	function automatic int cbr_depth(input int w);
		if (w == 9 || w == 18 || w == 36) begin
			return WIDE_BITS / w;
		end
		return NARROW_BITS / w;
	endfunction : cbr_depth

	// widths that may show old data on write
	function automatic bit cbr_old_ok(input int w);
		return (w == 9 || w == 18 || w == 36);
	endfunction : cbr_old_ok

endpackage : cbr_pkg

/* hw/cbr_port.sv */
// output stage of one memory port: write policy, pipeline, memory reset
`timescale 1ns/100ps
`default_nettype none
module cbr_port #(
	parameter int W = 18
) (
	input  wire logic   mclk,
	input  wire logic   rst,
	cbr_port_if.port    pif
);
	logic [W-1:0] latch_q;
	logic [W-1:0] latch_d;
	logic [W-1:0] out_q;
	logic         arst;
	logic         srst;

	// async mode clears at once, sync mode waits for the edge
	assign arst = pif.mem_rst & pif.async_rst;
	assign srst = rst | (pif.mem_rst & ~pif.async_rst);

	// ----------------------------------------------------------------
	// next value of the read latch
	// ----------------------------------------------------------------
	always_comb begin
		latch_d = latch_q;
		if (pif.hit && pif.we) begin
			case (pif.policy)
				cbr_pkg::CBR_WR_THROUGH: latch_d = pif.wdata;
				cbr_pkg::CBR_WR_OLD:     latch_d = pif.rd_raw;
				default:                 latch_d = latch_q;
			endcase
		end else if (pif.hit) begin
			latch_d = pif.rd_raw;
		end
	end

	always_ff @(posedge mclk or posedge arst) begin
		if (arst) begin
			latch_q <= '0;
		end else if (srst) begin
			latch_q <= '0;
		end else begin
			latch_q <= latch_d;
		end
	end

	// pipeline on: output takes the latch a cycle later
	always_ff @(posedge mclk or posedge arst) begin
		if (arst) begin
			out_q <= '0;
		end else if (srst) begin
			out_q <= '0;
		end else if (pif.pipe) begin
			out_q <= latch_q;
		end else begin
			out_q <= latch_d;
		end
	end

	assign pif.rdata = out_q;

endmodule : cbr_port
`default_nettype wire

/* hw/cbr_port_if.sv */
// link between the array core and one port output stage
`timescale 1ns/100ps
`default_nettype none
interface cbr_port_if #(parameter int W = 18);
	logic               hit;
	logic               we;
	logic [W-1:0]       wdata;
	logic [W-1:0]       rd_raw;
	logic               mem_rst;
	logic               pipe;
	logic               async_rst;
	cbr_pkg::cbr_policy_t policy;
	logic [W-1:0]       rdata;

	modport core (output hit, we, wdata, rd_raw, mem_rst, pipe, async_rst, policy, input rdata);
	modport port (input hit, we, wdata, rd_raw, mem_rst, pipe, async_rst, policy, output rdata);
endinterface
`default_nettype wire

/* hw/cbr_top.sv */
// configurable block ram: two ports, config over avalon-mm
`timescale 1ns/100ps
`default_nettype none
module cbr_top #(
	parameter int W = 18
) (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic [3:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	input  wire logic [3:0]                 avs_byteenable,
	output logic [31:0]                     avs_readdata,
	output logic                            avs_waitrequest,
	input  wire logic                       a_ce,
	input  wire logic                       a_we,
	input  wire logic [cbr_pkg::MATCH_W-1:0] a_sel,
	input  wire logic [cbr_pkg::ADDR_W-1:0] a_addr,
	input  wire logic [W-1:0]               a_wdata,
	input  wire logic                       a_mem_rst,
	output logic [W-1:0]                    a_rdata,
	input  wire logic                       b_ce,
	input  wire logic                       b_we,
	input  wire logic [cbr_pkg::MATCH_W-1:0] b_sel,
	input  wire logic [cbr_pkg::ADDR_W-1:0] b_addr,
	input  wire logic [W-1:0]               b_wdata,
	input  wire logic                       b_mem_rst,
	output logic [W-1:0]                    b_rdata
);
	localparam int          DEPTH = cbr_pkg::cbr_depth(W);
	localparam int          AW    = $clog2(DEPTH);
	localparam logic [7:0]  WIDTH_CODE = 8'(W);
	localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);

	logic [W-1:0]  mem [DEPTH];
	logic [31:0]   cfg;
	logic [31:0]   status;
	logic          clr_active_q;
	logic [AW-1:0] clr_addr_q;
	logic          hit_a;
	logic          hit_b;
	logic          we_a;
	logic          we_b;
	logic [AW-1:0] wa;
	logic [AW-1:0] wb;

	cbr_pkg::cbr_policy_t pol_a;
	cbr_pkg::cbr_policy_t pol_b;

	cbr_port_if #(.W(W)) pa ();
	cbr_port_if #(.W(W)) pb ();

	// ----------------------------------------------------------------
	// register slave
	// ----------------------------------------------------------------
	assign status = {16'h0000, WIDTH_CODE, 7'h00, clr_active_q};

	cbr_avl u_avl (
		.mclk            (mclk),
		.rst             (rst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.status          (status),
		.cfg             (cfg)
	);

	// old-data policy falls back to normal at narrow widths
	function automatic cbr_pkg::cbr_policy_t fix_policy(input logic [1:0] raw);
		cbr_pkg::cbr_policy_t p;
		p = cbr_pkg::cbr_policy_t'(raw);
		if (p == cbr_pkg::CBR_WR_OLD && !cbr_pkg::cbr_old_ok(W)) begin
			p = cbr_pkg::CBR_WR_NORMAL;
		end
		if (p == cbr_pkg::CBR_WR_SPARE) begin
			p = cbr_pkg::CBR_WR_NORMAL;
		end
		return p;
	endfunction : fix_policy

	// independent policy per port
	assign pol_a = fix_policy(cfg[cbr_pkg::CFG_POL_A +: 2]);
	assign pol_b = fix_policy(cfg[cbr_pkg::CFG_POL_B +: 2]);

	// ----------------------------------------------------------------
	// select decode; pseudo mode makes a write-only and b read-only
	// ----------------------------------------------------------------
	assign hit_a = a_ce & ~clr_active_q
		& (a_sel == cfg[cbr_pkg::CFG_MATCH_A +: cbr_pkg::MATCH_W])
		& (~cfg[cbr_pkg::CFG_PSEUDO] | a_we);
	assign hit_b = b_ce & ~clr_active_q
		& (b_sel == cfg[cbr_pkg::CFG_MATCH_B +: cbr_pkg::MATCH_W])
		& (~cfg[cbr_pkg::CFG_PSEUDO] | ~b_we);
	assign we_a = hit_a & a_we;
	assign we_b = hit_b & b_we & ~cfg[cbr_pkg::CFG_PSEUDO];
	assign wa   = a_addr[AW-1:0];
	assign wb   = b_addr[AW-1:0];

	// ----------------------------------------------------------------
	// global reset sweep, only when contents join the global reset
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			clr_active_q <= cfg[cbr_pkg::CFG_GSR];
			clr_addr_q   <= '0;
		end else if (clr_active_q) begin
			clr_addr_q <= clr_addr_q + 1'b1;
			if (clr_addr_q == LAST_ADDR) begin
				clr_active_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// array writes; b lands last on a same-address clash
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (clr_active_q) begin
			mem[clr_addr_q] <= '0;
		end else begin
			if (we_a) begin
				mem[wa] <= a_wdata;
			end
			if (we_b) begin
				mem[wb] <= b_wdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// port output stages
	// ----------------------------------------------------------------
	assign pa.hit       = hit_a;
	assign pa.we        = we_a;
	assign pa.wdata     = a_wdata;
	assign pa.rd_raw    = mem[wa];
	assign pa.mem_rst   = a_mem_rst;
	assign pa.pipe      = cfg[cbr_pkg::CFG_PIPE];
	assign pa.async_rst = cfg[cbr_pkg::CFG_ASYNC];
	assign pa.policy    = pol_a;

	assign pb.hit       = hit_b;
	assign pb.we        = we_b;
	assign pb.wdata     = b_wdata;
	assign pb.rd_raw    = mem[wb];
	assign pb.mem_rst   = b_mem_rst;
	assign pb.pipe      = cfg[cbr_pkg::CFG_PIPE];
	assign pb.async_rst = cfg[cbr_pkg::CFG_ASYNC];
	assign pb.policy    = pol_b;

	cbr_port #(.W(W)) u_port_a (
		.mclk (mclk),
		.rst  (rst),
		.pif  (pa)
	);

	cbr_port #(.W(W)) u_port_b (
		.mclk (mclk),
		.rst  (rst),
		.pif  (pb)
	);

	assign a_rdata = pa.rdata;
	assign b_rdata = pb.rdata;

endmodule : cbr_top
`default_nettype wire

/* test/cbr_fabric.sv */
// fabric-side model driving one memory port
`timescale 1ns/100ps
`default_nettype none
module cbr_fabric #(
	parameter int W = 36
) (
	input  wire logic                       mclk,
	output logic                            ce,
	output logic                            we,
	output logic [cbr_pkg::MATCH_W-1:0]     sel,
	output logic [cbr_pkg::ADDR_W-1:0]      addr,
	output logic [W-1:0]                    wdata,
	output logic                            mem_rst
);
	initial begin
		ce = 1'b0;
		we = 1'b0;
		sel = 3'h0;
		addr = 14'h0;
		wdata = '0;
		mem_rst = 1'b0;
	end

	// one access; caller keeps ports on distinct addresses
	task automatic acc(input logic w, input logic [2:0] s, input logic [13:0] a,
			input logic [W-1:0] d);
		ce <= 1'b1;
		we <= w;
		sel <= s;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		ce <= 1'b0;
		we <= 1'b0;
		addr <= ~a;
		wdata <= ~d;
	endtask : acc

	task automatic mrst(input logic v);
		mem_rst <= v;
	endtask : mrst
endmodule : cbr_fabric
`default_nettype wire

/* test/cbr_props.sv */
// port-level assertions for the block ram top
`timescale 1ns/100ps
`default_nettype none
module cbr_props #(
	parameter int W = 18
) (
	input  wire logic          mclk,
	input  wire logic          rst,
	input  wire logic [3:0]    avs_address,
	input  wire logic          avs_read,
	input  wire logic          avs_write,
	input  wire logic [31:0]   avs_readdata,
	input  wire logic          avs_waitrequest,
	input  wire logic          a_ce,
	input  wire logic          a_mem_rst,
	input  wire logic [W-1:0]  a_rdata,
	input  wire logic          b_ce,
	input  wire logic          b_mem_rst,
	input  wire logic [W-1:0]  b_rdata
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	property p_bus_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
	property p_bus_pulse;
		!avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_bus_pulse: assert property (p_bus_pulse) else $error("waitrequest low too long");
	property p_unmapped;
		avs_read && avs_waitrequest && avs_address != 4'h0 && avs_address != 4'h4
			|=> avs_readdata == 32'h0;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_rst_out;
		disable iff (1'b0) rst |=> avs_waitrequest && a_rdata == '0 && b_rdata == '0;
	endproperty
	a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
	property p_a_hold;
		(!a_ce && !a_mem_rst && !avs_write)[*3] |-> $stable(a_rdata);
	endproperty
	a_a_hold: assert property (p_a_hold) else $error("port a output moved while idle");
	property p_b_hold;
		(!b_ce && !b_mem_rst && !avs_write)[*3] |-> $stable(b_rdata);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("port b output moved while idle");
	property p_a_mrst;
		a_mem_rst && !a_ce |=> a_rdata == '0;
	endproperty
	a_a_mrst: assert property (p_a_mrst) else $error("port a memory reset missed");
	property p_b_mrst;
		b_mem_rst && !b_ce |=> b_rdata == '0;
	endproperty
	a_b_mrst: assert property (p_b_mrst) else $error("port b memory reset missed");
endmodule : cbr_props

bind cbr_top cbr_props #(.W(W)) u_cbr_props (
	.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.a_ce(a_ce), .a_mem_rst(a_mem_rst), .a_rdata(a_rdata),
	.b_ce(b_ce), .b_mem_rst(b_mem_rst), .b_rdata(b_rdata)
);
`default_nettype wire

/* test/configurable_block_ram_tb.sv */
// self-checking bench for the configurable block ram
`timescale 1ns/100ps
`default_nettype none
module configurable_block_ram_tb;
	localparam int W = 36;
	logic          mclk;
	logic          rst;
	logic [3:0]    avs_address;
	logic          avs_read;
	logic          avs_write;
	logic [31:0]   avs_writedata;
	logic [3:0]    avs_byteenable;
	logic [31:0]   avs_readdata;
	logic          avs_waitrequest;
	logic          a_ce, a_we, a_mem_rst, b_ce, b_we, b_mem_rst;
	logic [2:0]    a_sel, b_sel;
	logic [13:0]   a_addr, b_addr;
	logic [W-1:0]  a_wdata, a_rdata, b_wdata, b_rdata;
	logic [31:0]   rd;
	logic [35:0]   mem [0:15];
	int            fails = 0;
	int            checked = 0;

	cbr_top #(.W(W)) u_cbr_top (
		.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .a_ce(a_ce),
		.a_we(a_we), .a_sel(a_sel), .a_addr(a_addr), .a_wdata(a_wdata),
		.a_mem_rst(a_mem_rst), .a_rdata(a_rdata), .b_ce(b_ce), .b_we(b_we), .b_sel(b_sel),
		.b_addr(b_addr), .b_wdata(b_wdata), .b_mem_rst(b_mem_rst), .b_rdata(b_rdata));
	cbr_fabric #(.W(W)) u_fab_a (.mclk(mclk), .ce(a_ce), .we(a_we), .sel(a_sel),
		.addr(a_addr), .wdata(a_wdata), .mem_rst(a_mem_rst));
	cbr_fabric #(.W(W)) u_fab_b (.mclk(mclk), .ce(b_ce), .we(b_we), .sel(b_sel),
		.addr(b_addr), .wdata(b_wdata), .mem_rst(b_mem_rst));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic final_report;
		$display("compares %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		avs_address <= ad;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= ~wr;
		do begin
			@(negedge mclk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		@(posedge mclk);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 40) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, avs_waitrequest, 1'b0);
		end
		@(posedge mclk);
	endtask : bus

	// port access, then compare the output lat-1 edges after the edge that took it
	task automatic op(input logic p, input logic w, input logic [2:0] s, input logic [13:0] a,
			input logic [35:0] d, input int lat, input logic [35:0] exp);
		if (p)
			u_fab_b.acc(w, s, a, d);
		else
			u_fab_a.acc(w, s, a, d);
		repeat (lat - 1) @(posedge mclk);
		@(negedge mclk);
		chk(p ? b_rdata : a_rdata, exp);
		@(posedge mclk);
	endtask : op

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_regs;
		int n;
		n = 0;
		bus(1'b0, 4'h0, 32'h0);
		chk({4'h0, rd}, 36'h40);
		do begin
			bus(1'b0, 4'h4, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 400);
		chk({4'h0, rd}, 36'h2400);
		bus(1'b0, 4'hC, 32'h0);
		chk({4'h0, rd}, 36'h0);
		bus(1'b1, 4'h0, 32'hFFFF_FFFF);
		bus(1'b0, 4'h0, 32'h0);
		chk({4'h0, rd}, 36'h77FF);
		bus(1'b1, 4'h4, 32'hFFFF_FFFF);
		bus(1'b0, 4'h4, 32'h0);
		chk({4'h0, rd}, 36'h2400);
	endtask : t_regs

	task automatic t_policy;
		int pp;
		logic [13:0] ad;
		logic [35:0] nv;
		mem[6] = 36'h1_2345_6789;
		mem[10] = 36'hE_DCBA_9876;
		bus(1'b1, 4'h0, 32'h45);
		op(1'b0, 1'b1, 3'h0, 14'h6, mem[6], 1, mem[6]);
		op(1'b1, 1'b1, 3'h0, 14'hA, mem[10], 1, mem[10]);
		for (int pol = 0; pol < 3; pol++) begin
			bus(1'b1, 4'h0, 32'(32'h40 | pol | (((pol + 1) % 3) << 2)));
			for (int p = 0; p < 2; p++) begin
				pp = p ? (pol + 1) % 3 : pol;
				ad = p ? 14'h9 : 14'h5;
				nv = {4'h9, 24'h0, pol[3:0], p[3:0]};
				op(p[0], 1'b0, 3'h0, ad + 14'h1, 36'h0, 1, mem[ad + 14'h1]);
				op(p[0], 1'b1, 3'h0, ad, nv, 1,
					pp == 0 ? mem[ad + 14'h1] : pp == 1 ? nv : mem[ad]);
				mem[ad] = nv;
			end
		end
	endtask : t_policy

	task automatic t_sel;
		bus(1'b1, 4'h0, 32'h2740);
		op(1'b0, 1'b0, 3'h7, 14'h6, 36'h0, 1, mem[6]);
		op(1'b0, 1'b1, 3'h6, 14'h14, 36'h5_5555_5555, 1, mem[6]);
		op(1'b0, 1'b0, 3'h7, 14'h14, 36'h0, 1, 36'h0);
		op(1'b1, 1'b0, 3'h2, 14'hA, 36'h0, 1, mem[10]);
		op(1'b1, 1'b0, 3'h3, 14'h9, 36'h0, 1, mem[10]);
		// pseudo dual: a only writes, b only reads
		bus(1'b1, 4'h0, 32'hC0);
		op(1'b0, 1'b0, 3'h0, 14'h6, 36'h0, 1, 36'h0);
		op(1'b0, 1'b1, 3'h0, 14'h15, 36'h3_C3C3_C3C3, 1, 36'h0);
		op(1'b1, 1'b1, 3'h0, 14'h15, 36'h0_0000_0001, 1, mem[10]);
		op(1'b1, 1'b0, 3'h0, 14'h15, 36'h0, 1, 36'h3_C3C3_C3C3);
	endtask : t_sel

	task automatic t_pipe;
		bus(1'b1, 4'h0, 32'h50);
		op(1'b0, 1'b0, 3'h0, 14'h6, 36'h0, 2, mem[6]);
		op(1'b0, 1'b0, 3'h0, 14'h5, 36'h0, 1, mem[6]);
		@(negedge mclk);
		chk(a_rdata, mem[5]);
		@(posedge mclk);
	endtask : t_pipe

	task automatic t_mrst;
		bus(1'b1, 4'h0, 32'h40);
		op(1'b0, 1'b0, 3'h0, 14'h6, 36'h0, 1, mem[6]);
		u_fab_a.mrst(1'b1);
		@(negedge mclk);
		chk(a_rdata, mem[6]);
		@(posedge mclk);
		u_fab_a.mrst(1'b0);
		@(negedge mclk);
		chk(a_rdata, 36'h0);
		@(posedge mclk);
		bus(1'b1, 4'h0, 32'h60);
		op(1'b1, 1'b0, 3'h0, 14'hA, 36'h0, 1, mem[10]);
		u_fab_b.mrst(1'b1);
		#5;
		chk(b_rdata, 36'h0);
		@(posedge mclk);
		u_fab_b.mrst(1'b0);
		@(posedge mclk);
	endtask : t_mrst

	task automatic t_gsr;
		bus(1'b1, 4'h0, 32'h0);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		bus(1'b0, 4'h0, 32'h0);
		chk({4'h0, rd}, 36'h40);
		op(1'b0, 1'b0, 3'h0, 14'h5, 36'h0, 1, mem[5]);
	endtask : t_gsr

	initial begin
		#300000;
		fails++;
		final_report();
	end

	initial begin
		foreach (mem[i]) mem[i] = 36'h0;
		rst = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_regs();
		t_policy();
		t_sel();
		t_pipe();
		t_mrst();
		t_gsr();
		final_report();
	end
endmodule : configurable_block_ram_tb
`default_nettype wire
